// ### hdl/supply_supervisor_watchdog.sv
// Digital core of a supply supervisor: reset sequencing, watchdog, aux flag, write inhibit.
// Assumes analog comparators outside deliver clean levels and open-drain pads
// resolve out/oe pairs; one clock at sys_clk, async active-low rst_n.
`timescale 1ns/10ps

// ************************************************************
// Supervisor top
// ************************************************************
module supply_supervisor_watchdog #(
    parameter bit DUAL_OUTPUT = 1'b1,                // 1: both resets, 0: active-low only
    parameter bit WATCHDOG_EN = 1'b0,                // 1: watchdog variant
    parameter int unsigned RELEASE_CYC = sswd_pkg::RELEASE_CYC,
    parameter int unsigned WD_CYC = sswd_pkg::WD_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Comparator results
    input wire logic supplyLow,                      // Main supply below selected threshold
    input wire logic auxLow,                         // Aux sense below reference
    // Active-low reset pin, open-drain
    input wire logic rstLowPinIn,
    output logic rstLowPinOut_ff,
    output logic rstLowPinOe_ff,
    // Active-high reset pin, open-drain
    output logic rstHighPinOut_ff,
    output logic rstHighPinOe_ff,
    // Aux low indicator pin, open-drain
    output logic auxLowPinOut_ff,
    output logic auxLowPinOe_ff,
    // Watchdog kick from the host
    input wire logic watchdog_kick_in,
    // Memory write protection
    output logic writeInhibit_ff
);

    // ************************************************************
    // Declarations
    // ************************************************************
    sswd_pkg::sswd_pins_t pinsRaw;
    sswd_pkg::sswd_pins_t pinsSync;
    sswd_pkg::sswd_state_t state_ff;
    sswd_pkg::sswd_state_t nxt_state;
    logic [sswd_pkg::CNT_W-1:0] delayCnt_ff;
    logic [sswd_pkg::CNT_W-1:0] nxt_delayCnt;
    logic [sswd_pkg::CNT_W-1:0] wdCnt_ff;
    logic [sswd_pkg::CNT_W-1:0] nxt_wdCnt;
    logic kickPrev_ff;
    logic [sswd_pkg::CNT_W-1:0] releaseLast;
    logic [sswd_pkg::CNT_W-1:0] wdLast;
    logic [sswd_pkg::CNT_W-1:0] settleLast;
    logic kickEdge;
    logic manualReq;
    logic wdExpired;
    logic releaseDone;
    logic settleDone;
    logic wdRunning;
    logic nxt_resetActive;

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    // Both levels cross together through the two-stage synchroniser
    assign pinsRaw.rstPinLevel = rstLowPinIn;
    assign pinsRaw.kickLevel = watchdog_kick_in;

    sswd_sync #(
        .WIDTH(sswd_pkg::PINS_W),
        .RST_VAL(sswd_pkg::PINS_IDLE)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dIn(pinsRaw),
        .dOut(pinsSync)
    );

    // ************************************************************
    // Event decode
    // ************************************************************
    // Terminal counts, cut to counter width on purpose
    assign releaseLast = sswd_pkg::CNT_W'(RELEASE_CYC - 1);
    assign wdLast = sswd_pkg::CNT_W'(WD_CYC - 1);
    assign settleLast = sswd_pkg::SETTLE_CYC - sswd_pkg::CNT_ONE;

    // Kick edge: synchronised level against its previous sample
    assign kickEdge = WATCHDOG_EN && (pinsSync.kickLevel != kickPrev_ff);

    // Pin read low while we are not driving it means an outside party holds it.
    // Only trusted in RUN; SETTLE masks the pull-up rise after our own release.
    assign manualReq = (state_ff == sswd_pkg::SSWD_RUN) && !pinsSync.rstPinLevel;

    // Watchdog counts only while reset is released and the variant has it
    assign wdRunning = WATCHDOG_EN && (state_ff == sswd_pkg::SSWD_RUN);
    assign wdExpired = wdRunning && !kickEdge && (wdCnt_ff == wdLast);

    assign releaseDone = (delayCnt_ff == releaseLast);
    assign settleDone = (delayCnt_ff == settleLast);

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    // Supply low always wins and restarts the whole delay, whatever the state
    always_comb begin
        nxt_state = state_ff;
        nxt_delayCnt = delayCnt_ff;
        case (state_ff)
            sswd_pkg::SSWD_RUN: begin
                nxt_delayCnt = sswd_pkg::CNT_ZERO;
                if (supplyLow) begin
                    nxt_state = sswd_pkg::SSWD_ASSERT;
                end else if (manualReq || wdExpired) begin
                    // Manual and watchdog causes share the recovery delay
                    nxt_state = sswd_pkg::SSWD_DELAY;
                end
            end
            sswd_pkg::SSWD_ASSERT: begin
                nxt_delayCnt = sswd_pkg::CNT_ZERO;
                if (!supplyLow) begin
                    nxt_state = sswd_pkg::SSWD_DELAY;
                end
            end
            sswd_pkg::SSWD_DELAY: begin
                if (supplyLow) begin
                    nxt_state = sswd_pkg::SSWD_ASSERT;
                    nxt_delayCnt = sswd_pkg::CNT_ZERO;
                end else if (releaseDone) begin
                    nxt_state = sswd_pkg::SSWD_SETTLE;
                    nxt_delayCnt = sswd_pkg::CNT_ZERO;
                end else begin
                    nxt_delayCnt = delayCnt_ff + sswd_pkg::CNT_ONE;
                end
            end
            sswd_pkg::SSWD_SETTLE: begin
                if (supplyLow) begin
                    nxt_state = sswd_pkg::SSWD_ASSERT;
                    nxt_delayCnt = sswd_pkg::CNT_ZERO;
                end else if (settleDone) begin
                    nxt_state = sswd_pkg::SSWD_RUN;
                    nxt_delayCnt = sswd_pkg::CNT_ZERO;
                end else begin
                    nxt_delayCnt = delayCnt_ff + sswd_pkg::CNT_ONE;
                end
            end
            default: begin
                nxt_state = sswd_pkg::SSWD_ASSERT;
                nxt_delayCnt = sswd_pkg::CNT_ZERO;
            end
        endcase
    end

    // Reset pins are active in ASSERT and DELAY only
    assign nxt_resetActive = (nxt_state == sswd_pkg::SSWD_ASSERT) ||
                             (nxt_state == sswd_pkg::SSWD_DELAY);

    // Power-up enters ASSERT so resets are active until supply is seen good
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= sswd_pkg::SSWD_ASSERT;
            delayCnt_ff <= sswd_pkg::CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            delayCnt_ff <= nxt_delayCnt;
        end
    end

    // ************************************************************
    // Watchdog
    // ************************************************************
    // Any kick edge restarts from zero; held cleared outside RUN so a
    // fresh full timeout starts each time reset is released
    always_comb begin
        nxt_wdCnt = sswd_pkg::CNT_ZERO;
        if (!wdRunning || kickEdge) begin
            nxt_wdCnt = sswd_pkg::CNT_ZERO;
        end else if (!wdExpired) begin
            nxt_wdCnt = wdCnt_ff + sswd_pkg::CNT_ONE;
        end
    end

    // Kick history is tracked always, so an edge during reset is not
    // mistaken for one when counting resumes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt_ff <= sswd_pkg::CNT_ZERO;
            kickPrev_ff <= sswd_pkg::PINS_IDLE.kickLevel;
        end else begin
            wdCnt_ff <= nxt_wdCnt;
            kickPrev_ff <= pinsSync.kickLevel;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Open-drain pairs: the out level is fixed, only the enable moves.
    // Single-output builds never enable the active-high pad.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstLowPinOut_ff <= 1'b0;
            rstLowPinOe_ff <= 1'b1;
            rstHighPinOut_ff <= 1'b1;
            rstHighPinOe_ff <= DUAL_OUTPUT;
        end else begin
            rstLowPinOut_ff <= 1'b0;
            rstLowPinOe_ff <= nxt_resetActive;
            rstHighPinOut_ff <= 1'b1;
            rstHighPinOe_ff <= DUAL_OUTPUT && nxt_resetActive;
        end
    end

    // Aux flag follows the comparator; pulled low while sense is under reference
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            auxLowPinOut_ff <= 1'b0;
            auxLowPinOe_ff <= 1'b0;
        end else begin
            auxLowPinOut_ff <= 1'b0;
            auxLowPinOe_ff <= auxLow;
        end
    end

    // Inhibit starts active and drops only once supply is good; it tracks
    // supply alone, so a watchdog or manual reset leaves writes allowed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            writeInhibit_ff <= 1'b1;
        end else begin
            writeInhibit_ff <= supplyLow;
        end
    end

endmodule : supply_supervisor_watchdog

// ### hdl/sswd_pkg.sv
// Shared constants and types of the supply supervisor with watchdog.
// Assumes a single free-running system clock at CLK_HZ and an active-low async reset.
package sswd_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam longint CLK_HZ = 10_000_000;          // System clock rate
    localparam int CNT_W = 24;                       // Width of the delay counters

    // Reset release delay after the last cause goes away
    localparam longint RELEASE_DELAY_MS = 200;
    // Least time: round up to whole cycles, never below one
    localparam longint RELEASE_CYC_L = (RELEASE_DELAY_MS * CLK_HZ + 999) / 1000;
    localparam int unsigned RELEASE_CYC = (RELEASE_CYC_L < 1) ? 1 : int'(RELEASE_CYC_L);

    // Watchdog timeout without a kick transition
    localparam real WD_TIMEOUT_S = 1.6;
    // Longest time: round down to whole cycles, never below one
    localparam longint WD_CYC_L = longint'($floor(WD_TIMEOUT_S * real'(CLK_HZ)));
    localparam int unsigned WD_CYC = (WD_CYC_L < 1) ? 1 : int'(WD_CYC_L);

    // Cycles the reset pin is ignored after release, covering synchroniser
    // latency plus pull-up rise, so our own drive is not seen as a manual press
    localparam logic [CNT_W-1:0] SETTLE_CYC = 24'h000004;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    // ************************************************************
    // Types
    // ************************************************************
    // Sequencer states, Gray coded along run -> assert -> delay -> settle
    typedef enum logic [1:0] {
        SSWD_RUN    = 2'h0,
        SSWD_ASSERT = 2'h1,
        SSWD_DELAY  = 2'h3,
        SSWD_SETTLE = 2'h2
    } sswd_state_t;

    // Pin levels that cross into the clock domain together
    typedef struct packed {
        logic rstPinLevel;                           // Active-low reset pin as seen on the wire
        logic kickLevel;                             // Watchdog kick input level
    } sswd_pins_t;

    localparam int PINS_W = $bits(sswd_pins_t);
    // Idle values: pin pulled high, kick low
    localparam sswd_pins_t PINS_IDLE = '{rstPinLevel: 1'b1, kickLevel: 1'b0};

endpackage : sswd_pkg

// ### hdl/sswd_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are plain levels; only the second stage may be used downstream.
`timescale 1ns/10ps
module sswd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Levels in and out
    input wire logic [WIDTH-1:0] dIn,
    output logic [WIDTH-1:0] dOut
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end else begin
            stage1_ff <= dIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign dOut = stage2_ff;

endmodule : sswd_sync

// ### dv/sswd_assertions.sv
// Checker of the supervisor top, watching its ports only.
// Assumes one clock and async active-low reset; bound at the foot.
`timescale 1ns/10ps
// ********
// Checker
// ********
module sswd_assertions #(
    parameter bit DUAL_OUTPUT = 1'b1,
    parameter bit WATCHDOG_EN = 1'b0,
    parameter int unsigned RELEASE_CYC = sswd_pkg::RELEASE_CYC,
    parameter int unsigned WD_CYC = sswd_pkg::WD_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Design inputs
    input wire logic supplyLow,
    input wire logic auxLow,
    input wire logic rstLowPinIn,
    input wire logic watchdog_kick_in,
    // Design outputs
    input wire logic rstLowPinOut_ff,
    input wire logic rstLowPinOe_ff,
    input wire logic rstHighPinOut_ff,
    input wire logic rstHighPinOe_ff,
    input wire logic auxLowPinOut_ff,
    input wire logic auxLowPinOe_ff,
    input wire logic writeInhibit_ff
);
    // Slack for sync, settle and output register past the timeout
    localparam int WD_LATE = int'(WD_CYC) + 10;
    logic [31:0] holdCnt_ff;
    logic [31:0] kickAge_ff;
    logic kickPrev_ff;
    // Hold counts only once every supply cause is gone
    wire logic [31:0] nxt_holdCnt = (rstLowPinOe_ff && !supplyLow) ? holdCnt_ff + 32'h1 : 32'h0;
    wire logic kickEdge = watchdog_kick_in != kickPrev_ff;
    wire logic [31:0] nxt_kickAge = (rstLowPinOe_ff || kickEdge) ? 32'h0 : kickAge_ff + 32'h1;
    // Helper counters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            holdCnt_ff <= 32'h0;
            kickAge_ff <= 32'h0;
            kickPrev_ff <= 1'b0;
        end else begin
            holdCnt_ff <= nxt_holdCnt;
            kickAge_ff <= nxt_kickAge;
            kickPrev_ff <= watchdog_kick_in;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence pinHeld;
        (!rstLowPinOe_ff && !rstLowPinIn) [*3];
    endsequence
    sequence pinFall;
        $fell(rstLowPinIn) && !rstLowPinOe_ff && !supplyLow;
    endsequence
    supply_assert_a: assert property (supplyLow |-> ##[0:2] rstLowPinOe_ff)
        else $error("reset not driven on low supply");
    supply_hold_a: assert property (supplyLow ##1 supplyLow |-> rstLowPinOe_ff)
        else $error("reset dropped while supply low");
    release_len_a: assert property ($fell(rstLowPinOe_ff) |->
        holdCnt_ff >= RELEASE_CYC - 2 && holdCnt_ff <= RELEASE_CYC + 3)
        else $error("release delay wrong length");
    high_tie_a: assert property (rstHighPinOe_ff == (DUAL_OUTPUT && rstLowPinOe_ff))
        else $error("high reset disagrees with low reset");
    od_level_a: assert property (!rstLowPinOut_ff && rstHighPinOut_ff && !auxLowPinOut_ff)
        else $error("open drain level wrong");
    aux_follow_a: assert property (auxLowPinOe_ff == $past(auxLow))
        else $error("aux flag does not follow sense");
    inhibit_set_a: assert property (supplyLow |=> writeInhibit_ff)
        else $error("writes open on low supply");
    inhibit_rel_a: assert property ($fell(writeInhibit_ff) |-> !$past(supplyLow))
        else $error("write inhibit released early");
    manual_rst_a: assert property (pinHeld |-> ##[0:8] rstLowPinOe_ff)
        else $error("manual press not taken");
    sync_lag_a: assert property (pinFall |=> !rstLowPinOe_ff)
        else $error("pin taken without two stages");
    wd_late_a: assert property (WATCHDOG_EN && kickAge_ff == WD_LATE |-> rstLowPinOe_ff)
        else $error("watchdog timeout missed");
endmodule : sswd_assertions
bind supply_supervisor_watchdog sswd_assertions #(.DUAL_OUTPUT(DUAL_OUTPUT),
    .WATCHDOG_EN(WATCHDOG_EN), .RELEASE_CYC(RELEASE_CYC), .WD_CYC(WD_CYC)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .supplyLow(supplyLow), .auxLow(auxLow),
    .rstLowPinIn(rstLowPinIn), .watchdog_kick_in(watchdog_kick_in),
    .rstLowPinOut_ff(rstLowPinOut_ff), .rstLowPinOe_ff(rstLowPinOe_ff),
    .rstHighPinOut_ff(rstHighPinOut_ff), .rstHighPinOe_ff(rstHighPinOe_ff),
    .auxLowPinOut_ff(auxLowPinOut_ff), .auxLowPinOe_ff(auxLowPinOe_ff),
    .writeInhibit_ff(writeInhibit_ff));

// ### dv/sswd_host_model.sv
// Host controller model: kicks the watchdog and presses reset.
// Assumes the bench resolves the reset wire and feeds its level back.
`timescale 1ns/10ps
module sswd_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control from the bench
    input wire logic kickEn,
    input wire logic [7:0] kickPeriod,
    input wire logic pressReq,
    input wire logic pinLevel,
    // Toward the supervisor
    output logic kickOut_ff,
    output logic pressLow_ff
);
    logic [7:0] cnt_ff;
    wire logic wrapNow = cnt_ff >= kickPeriod - 8'h01;
    // A host held in reset runs no code, so it cannot kick then
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            kickOut_ff <= 1'b0;
            pressLow_ff <= 1'b0;
        end else begin
            cnt_ff <= (!kickEn || !pinLevel || wrapNow) ? 8'h00 : cnt_ff + 8'h01;
            kickOut_ff <= kickOut_ff ^ (kickEn && pinLevel && wrapNow);
            pressLow_ff <= pressReq;
        end
    end
endmodule : sswd_host_model

// ### dv/testbench.sv
// Self-checking bench of the supervisor with watchdog.
// Assumes short delay parameters; the reset wire has a pull-up.
`timescale 1ns/10ps
module testbench;
    localparam int unsigned RC = 20;
    localparam int unsigned WD = 50;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic supplyLow = 1'b1;
    logic auxLow = 1'b0;
    logic kickEn = 1'b1;
    logic [7:0] kickPeriod = 8'h14;
    logic pressReq = 1'b0;
    logic kickWire, pressLow, lowOe, highOe, auxOe, wrInh;
    wire logic rstPin = !(lowOe || pressLow);
    logic lowOeS, highOeS;
    // Second build has a pin of its own, so only the host press reaches both
    wire logic rstPinS = !(lowOeS || pressLow);
    int n_mismatch = 0;
    int check_count = 0;
    int expQ[$];
    int holdSeen = 0;
    logic oePrev = 1'b1;
    logic [31:0] seed = 32'h95BB2148;
    always #50 sys_clk = ~sys_clk;
    supply_supervisor_watchdog #(.DUAL_OUTPUT(1'b1), .WATCHDOG_EN(1'b1),
        .RELEASE_CYC(RC), .WD_CYC(WD)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .supplyLow(supplyLow), .auxLow(auxLow), .rstLowPinIn(rstPin),
        .rstLowPinOut_ff(), .rstLowPinOe_ff(lowOe), .rstHighPinOut_ff(),
        .rstHighPinOe_ff(highOe), .auxLowPinOut_ff(), .auxLowPinOe_ff(auxOe),
        .watchdog_kick_in(kickWire), .writeInhibit_ff(wrInh));
    // Single-output build without watchdog; its active-high pad must stay off
    supply_supervisor_watchdog #(.DUAL_OUTPUT(1'b0), .WATCHDOG_EN(1'b0),
        .RELEASE_CYC(RC), .WD_CYC(WD)) dutSingle (.sys_clk(sys_clk), .rst_n(rst_n),
        .supplyLow(supplyLow), .auxLow(auxLow), .rstLowPinIn(rstPinS),
        .rstLowPinOut_ff(), .rstLowPinOe_ff(lowOeS), .rstHighPinOut_ff(),
        .rstHighPinOe_ff(highOeS), .auxLowPinOut_ff(), .auxLowPinOe_ff(),
        .watchdog_kick_in(kickWire), .writeInhibit_ff());
    sswd_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .kickEn(kickEn),
        .kickPeriod(kickPeriod), .pressReq(pressReq), .pinLevel(rstPin),
        .kickOut_ff(kickWire), .pressLow_ff(pressLow));
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : check
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Bounded wait; a missed pulse leaves its note queued
    task waitOe(input logic lvl, input int lim);
        int k;
        k = 0;
        while (lowOe !== lvl && k < lim) begin
            @(posedge sys_clk);
            k++;
        end
    endtask : waitOe
    // Each reset release takes the oldest note; none queued means spurious
    always @(posedge sys_clk) begin
        int e;
        if (rst_n && oePrev === 1'b1 && lowOe === 1'b0) begin
            if (expQ.size() == 0) check(32'h0, 32'h1);
            else begin
                e = expQ.pop_front();
                check((holdSeen >= e - 2 && holdSeen <= e + 3) ? e : holdSeen, e);
            end
        end
        holdSeen = (lowOe && !supplyLow) ? holdSeen + 1 : 0;
        oePrev = lowOe;
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        logic [31:0] r;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check(wrInh, 1'b1);
        check({lowOe, highOe}, 2'h3);
        check({lowOeS, highOeS}, 2'h2);
        supplyLow <= 1'b0;
        expQ.push_back(RC);
        waitOe(1'b0, RC + 10);
        repeat (8) @(posedge sys_clk);
        check(wrInh, 1'b0);
        // Brownout that strikes again inside the delay
        supplyLow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        supplyLow <= 1'b0;
        repeat (10) @(posedge sys_clk);
        supplyLow <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({lowOe, highOe, wrInh}, 3'h7);
        supplyLow <= 1'b0;
        expQ.push_back(RC);
        waitOe(1'b0, RC + 10);
        repeat (8) @(posedge sys_clk);
        // Random aux sense levels
        repeat (30) begin
            r = xorshift();
            auxLow <= r[0];
            @(posedge sys_clk);
            @(negedge sys_clk);
            check(auxOe, r[0]);
            @(posedge sys_clk);
        end
        // Kicks at random spacing, last one near the limit
        repeat (8) begin
            kickPeriod <= 8'h0A + 8'(r[4:0]);
            r = xorshift();
            repeat (60) @(posedge sys_clk);
        end
        kickPeriod <= 8'(WD - 4);
        repeat (150) @(posedge sys_clk);
        // Manual press of random length
        kickPeriod <= 8'h14;
        pressReq <= 1'b1;
        repeat (2 + r[1:0]) @(posedge sys_clk);
        pressReq <= 1'b0;
        expQ.push_back(RC);
        waitOe(1'b1, 10);
        waitOe(1'b0, RC + 10);
        repeat (8) @(posedge sys_clk);
        // Host stops kicking
        kickEn <= 1'b0;
        expQ.push_back(RC);
        waitOe(1'b1, WD + 20);
        // Only the watchdog build times out; the other keeps its reset released
        check({lowOe, lowOeS, highOeS}, 3'h4);
        kickEn <= 1'b1;
        waitOe(1'b0, RC + 10);
        repeat (60) @(posedge sys_clk);
        check(32'(expQ.size()), 32'h0);
        check(lowOe, 1'b0);
        wrap_up();
    end
endmodule : testbench
